// >>> hdl/sew_cfg.svh
`ifndef SEW_CFG_SVH
`define SEW_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SEW_CLK_NS     5
`define SEW_TCSL_NS    250
`define SEW_PROG_NS    5000000
`define SEW_SCLK_HALF  8'h08
`define SEW_GAP_W      8

// ----------------------------------------------------------------
// instruction format
// ----------------------------------------------------------------
`define SEW_OP_READ    2'h2
`define SEW_OP_WRITE   2'h1
`define SEW_OP_ERASE   2'h3
`define SEW_OP_LEN     5'h01
`define SEW_HDR_BITS   5'h03
`define SEW_X8_ABITS   5'h08
`define SEW_X16_ABITS  5'h07
`define SEW_X8_DBITS   5'h08
`define SEW_X16_DBITS  5'h10
`define SEW_TX_W       26
`define SEW_X8_PAD     7'h00

// ----------------------------------------------------------------
// array
// ----------------------------------------------------------------
`define SEW_MEM_BYTES  256
`define SEW_ERASED_W   16'hffff
`define SEW_BYTE_LO    1'b0
`define SEW_BYTE_HI    1'b1

// ----------------------------------------------------------------
// device synchroniser lanes
// ----------------------------------------------------------------
`define SEW_SY_W       5
`define SEW_SY_SEL     0
`define SEW_SY_DONE    1
`define SEW_SY_START   2
`define SEW_SY_RBIT    3
`define SEW_SY_RON     4

`endif

// >>> hdl/sew_pkg.sv
package sew_pkg;

	typedef enum logic [1:0] {
		SEW_VAR_STRAP,
		SEW_VAR_X8,
		SEW_VAR_X16
	} sew_variant_t;

	typedef enum {
		SEW_D_IDLE,
		SEW_D_OP,
		SEW_D_ADDR,
		SEW_D_DATA,
		SEW_D_READ,
		SEW_D_DONE
	} sew_dstate_t;

	typedef enum {
		SEW_M_IDLE,
		SEW_M_SHIFT,
		SEW_M_READ,
		SEW_M_DROP,
		SEW_M_GAP,
		SEW_M_POLL,
		SEW_M_CLEAR
	} sew_mstate_t;

endpackage : sew_pkg

// >>> hdl/sew_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sew_link_if;
	logic sel;
	logic sclk;
	logic sdin;
	logic sdout;
	logic sdout_oe_n;

	modport dev (
		input  sel,
		input  sclk,
		input  sdin,
		output sdout,
		output sdout_oe_n
	);

	modport mst (
		output sel,
		output sclk,
		output sdin,
		input  sdout,
		input  sdout_oe_n
	);
endinterface : sew_link_if

`default_nettype wire

// >>> hdl/sew_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "sew_cfg.svh"

// Operation
// - select high selects, low means standby
// - running programming finishes despite select
// - master keeps select low 250 ns between
// - select low holds instruction logic reset
// - serial input sampled on rising clock
// - output bit shifted on rising clock
// - clock may pause anywhere without loss
// - clock ignored while select low
// - zeros before start change nothing
// - programming is self-timed, no clock
// - except reads: exact edge count, then ignore until select low
// - status driven when reselected after programming
// - select low throughout keeps output floating
// - finished programming shows output high
// - start bit after programming ends, then select low clears status
// - strap high x16, low x8
// - fixed variants ignore the strap
// - busy shows low, done shows high
module sew_dev #(
	parameter sew_pkg::sew_variant_t VARIANT     = sew_pkg::SEW_VAR_STRAP,
	parameter int unsigned           PROG_CYCLES = `SEW_PROG_NS / `SEW_CLK_NS
)(
	// system side
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// strap and status
	input  wire logic width_strap,
	output logic      busy,
	// link
	sew_link_if.dev   link
);

	// ------------------------------------------------------------
	// storage and helpers
	// ------------------------------------------------------------
	logic [7:0] mem [`SEW_MEM_BYTES];

	function automatic logic [4:0] addr_bits(input logic x16);
		addr_bits = x16 ? `SEW_X16_ABITS : `SEW_X8_ABITS;
	endfunction : addr_bits

	function automatic logic [4:0] data_bits(input logic x16);
		data_bits = x16 ? `SEW_X16_DBITS : `SEW_X8_DBITS;
	endfunction : data_bits

	// x8 data sits in the top byte so the shifter always emits bit 15
	function automatic logic [15:0] rd_word(input logic [7:0] ptr,
		input logic x16);
		if (x16)
			rd_word = {mem[{ptr[6:0], `SEW_BYTE_HI}],
				mem[{ptr[6:0], `SEW_BYTE_LO}]};
		else
			rd_word = {mem[ptr], 8'h00};
	endfunction : rd_word

	// ------------------------------------------------------------
	// link clock domain
	// ------------------------------------------------------------
	sew_pkg::sew_dstate_t st;
	logic        s1_strap;
	logic        s2_strap;
	logic        x16_now;
	logic [4:0]  cnt;
	logic [1:0]  op;
	logic [7:0]  addr;
	logic [7:0]  next_addr;
	logic [15:0] wdata;
	logic [15:0] sreg;
	logic [15:0] word;
	logic [7:0]  ptr;
	logic        cmd_x16;
	logic        rd_bit;
	logic        rd_on;
	logic        cmd_done;
	logic        start_seen;

	always_ff @(posedge link.sclk)
	begin
		s1_strap <= width_strap;
		s2_strap <= s1_strap;
	end

	always_comb
	begin
		x16_now = (VARIANT == sew_pkg::SEW_VAR_X16) ||
			((VARIANT == sew_pkg::SEW_VAR_STRAP) && s2_strap);
		next_addr = {addr[6:0], link.sdin};
		word = rd_word(ptr + 8'h01, cmd_x16);
	end

	// state is held between edges, so a stopped clock loses nothing
	always_ff @(posedge link.sclk or negedge link.sel)
	begin
		if (!link.sel)
		begin
			st         <= sew_pkg::SEW_D_IDLE;
			cnt        <= 5'h00;
			op         <= 2'h0;
			addr       <= 8'h00;
			wdata      <= 16'h0000;
			sreg       <= 16'h0000;
			ptr        <= 8'h00;
			cmd_x16    <= 1'b0;
			rd_bit     <= 1'b0;
			rd_on      <= 1'b0;
			cmd_done   <= 1'b0;
			start_seen <= 1'b0;
		end
		else
		begin
			case (st)
				sew_pkg::SEW_D_IDLE:
				begin
					if (link.sdin)
					begin
						st         <= sew_pkg::SEW_D_OP;
						cnt        <= `SEW_OP_LEN;
						start_seen <= 1'b1;
						cmd_x16    <= x16_now;
					end
				end
				sew_pkg::SEW_D_OP:
				begin
					op <= {op[0], link.sdin};
					if (cnt == 5'h00)
					begin
						st  <= sew_pkg::SEW_D_ADDR;
						cnt <= addr_bits(cmd_x16) - 5'h01;
					end
					else
						cnt <= cnt - 5'h01;
				end
				sew_pkg::SEW_D_ADDR:
				begin
					addr <= next_addr;
					if (cnt != 5'h00)
						cnt <= cnt - 5'h01;
					else if (op == `SEW_OP_READ)
					begin
						st     <= sew_pkg::SEW_D_READ;
						ptr    <= next_addr;
						sreg   <= rd_word(next_addr, cmd_x16);
						cnt    <= data_bits(cmd_x16);
						rd_bit <= 1'b0;
						rd_on  <= 1'b1;
					end
					else if (op == `SEW_OP_WRITE)
					begin
						st  <= sew_pkg::SEW_D_DATA;
						cnt <= data_bits(cmd_x16) - 5'h01;
					end
					else
					begin
						st       <= sew_pkg::SEW_D_DONE;
						cmd_done <= (op == `SEW_OP_ERASE);
					end
				end
				sew_pkg::SEW_D_DATA:
				begin
					wdata <= {wdata[14:0], link.sdin};
					if (cnt == 5'h00)
					begin
						st       <= sew_pkg::SEW_D_DONE;
						cmd_done <= 1'b1;
					end
					else
						cnt <= cnt - 5'h01;
				end
				sew_pkg::SEW_D_READ:
				begin
					// sequential read rolls into the next location
					if (cnt == 5'h00)
					begin
						ptr    <= ptr + 8'h01;
						rd_bit <= word[15];
						sreg   <= {word[14:0], 1'b0};
						cnt    <= data_bits(cmd_x16) - 5'h01;
					end
					else
					begin
						rd_bit <= sreg[15];
						sreg   <= {sreg[14:0], 1'b0};
						cnt    <= cnt - 5'h01;
					end
				end
				sew_pkg::SEW_D_DONE:
				begin
					st <= sew_pkg::SEW_D_DONE;
				end
				default:
					st <= sew_pkg::SEW_D_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// system clock domain
	// ------------------------------------------------------------
	logic [`SEW_SY_W-1:0] sy1;
	logic [`SEW_SY_W-1:0] sy2;
	logic        sel_s;
	logic        pend;
	logic [1:0]  p_op;
	logic [7:0]  p_addr;
	logic [15:0] p_data;
	logic        p_x16;
	logic [31:0] tmr;
	logic        stat_armed;
	logic        clr_pend;
	logic [15:0] wr_val;

	always_ff @(posedge clk)
	begin
		sy1 <= {rd_on, rd_bit, start_seen, cmd_done, link.sel};
		sy2 <= sy1;
	end

	always_comb
	begin
		sel_s  = sy2[`SEW_SY_SEL];
		wr_val = (p_op == `SEW_OP_ERASE) ? `SEW_ERASED_W : p_data;
	end

	// command fields hold still once done is raised, so the synced
	// done level qualifies them; select must stay high for at least
	// three clk cycles after the last clock edge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pend       <= 1'b0;
			p_op       <= 2'h0;
			p_addr     <= 8'h00;
			p_data     <= 16'h0000;
			p_x16      <= 1'b0;
			busy       <= 1'b0;
			tmr        <= 32'h0000_0000;
			stat_armed <= 1'b0;
			clr_pend   <= 1'b0;
		end
		else if (ce)
		begin
			if (busy)
			begin
				if (tmr == 32'h0000_0000)
					busy <= 1'b0;
				else
					tmr <= tmr - 32'h0000_0001;
			end
			if (sy2[`SEW_SY_START] && stat_armed && !busy && sel_s)
				clr_pend <= 1'b1;
			else if (clr_pend && !sel_s)
			begin
				clr_pend   <= 1'b0;
				stat_armed <= 1'b0;
			end
			if (!pend && !busy && sel_s && sy2[`SEW_SY_DONE])
			begin
				pend   <= 1'b1;
				p_op   <= op;
				p_addr <= addr;
				p_data <= wdata;
				p_x16  <= cmd_x16;
			end
			else if (pend && !sel_s)
			begin
				// programming starts on the falling select, then
				// runs whatever select does
				pend       <= 1'b0;
				busy       <= 1'b1;
				tmr        <= 32'(PROG_CYCLES - 1);
				stat_armed <= 1'b1;
				clr_pend   <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce && busy && (tmr == 32'h0000_0000))
		begin
			if (p_x16)
			begin
				mem[{p_addr[6:0], `SEW_BYTE_HI}] <= wr_val[15:8];
				mem[{p_addr[6:0], `SEW_BYTE_LO}] <= wr_val[7:0];
			end
			else
				mem[p_addr] <= wr_val[7:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link.sdout      <= 1'b0;
			link.sdout_oe_n <= 1'b1;
		end
		else if (ce)
		begin
			if (!sel_s)
				link.sdout_oe_n <= 1'b1;
			else if (stat_armed)
			begin
				link.sdout_oe_n <= 1'b0;
				link.sdout      <= !busy;
			end
			else if (sy2[`SEW_SY_RON])
			begin
				link.sdout_oe_n <= 1'b0;
				link.sdout      <= sy2[`SEW_SY_RBIT];
			end
			else
				link.sdout_oe_n <= 1'b1;
		end
	end

endmodule : sew_dev

`default_nettype wire

// >>> hdl/sew_mst.sv
`timescale 1ns/1ps
`default_nettype none
`include "sew_cfg.svh"

module sew_mst (
	// system side
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// requests
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [1:0]  req_op,
	input  wire logic [7:0]  req_addr,
	input  wire logic [15:0] req_data,
	input  wire logic        req_x16,
	// answers
	output logic             rsp_valid,
	output logic [15:0]      rsp_data,
	// link
	sew_link_if.mst          link
);

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int TCSL_CYC =
		(`SEW_TCSL_NS + `SEW_CLK_NS - 1) / `SEW_CLK_NS;
	localparam logic [7:0] HALF = `SEW_SCLK_HALF;
	localparam logic [7:0] LAST = 8'((2 * HALF) - 1);
	localparam logic [`SEW_GAP_W-1:0] GAP = `SEW_GAP_W'(TCSL_CYC);

	sew_pkg::sew_mstate_t st;
	logic [7:0]            ph;
	logic [`SEW_GAP_W-1:0] gcnt;
	logic                  gap_ok;
	logic [`SEW_TX_W-1:0]  tx;
	logic [4:0]            nleft;
	logic [15:0]           rsh;
	logic                  prog;
	logic                  rd;
	logic                  x16;
	logic                  do1;
	logic                  do2;

	always_ff @(posedge clk)
	begin
		// a released line reads as busy, never as a stale ready
		do1 <= !link.sdout_oe_n && link.sdout;
		do2 <= do1;
	end

	assign gap_ok = (gcnt == GAP);

	// ------------------------------------------------------------
	// sequencer: the link clock is a divided copy of clk
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st        <= sew_pkg::SEW_M_IDLE;
			ph        <= 8'h00;
			gcnt      <= '0;
			link.sel  <= 1'b0;
			link.sclk <= 1'b0;
			link.sdin <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
			tx        <= '0;
			nleft     <= 5'h00;
			rsh       <= 16'h0000;
			prog      <= 1'b0;
			rd        <= 1'b0;
			x16       <= 1'b0;
		end
		else if (ce)
		begin
			rsp_valid <= 1'b0;
			ph        <= (ph == LAST) ? 8'h00 : ph + 8'h01;
			if (link.sel)
				gcnt <= '0;
			else if (!gap_ok)
				gcnt <= gcnt + 1'b1;
			if (ph == 8'h00)
				link.sclk <= 1'b0;
			case (st)
				sew_pkg::SEW_M_IDLE:
				begin
					req_ready <= gap_ok;
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						link.sel  <= 1'b1;
						ph        <= 8'h00;
						st        <= sew_pkg::SEW_M_SHIFT;
						x16       <= req_x16;
						rd        <= (req_op == `SEW_OP_READ);
						prog      <= (req_op == `SEW_OP_WRITE) ||
							(req_op == `SEW_OP_ERASE);
						tx <= req_x16 ?
							{1'b1, req_op, req_addr[6:0], req_data} :
							{1'b1, req_op, req_addr, req_data[7:0],
							`SEW_X8_PAD};
						nleft <= `SEW_HDR_BITS +
							(req_x16 ? `SEW_X16_ABITS : `SEW_X8_ABITS) +
							((req_op != `SEW_OP_WRITE) ? 5'h00 :
							(req_x16 ? `SEW_X16_DBITS : `SEW_X8_DBITS));
					end
				end
				sew_pkg::SEW_M_SHIFT:
				begin
					if (ph == 8'h00)
					begin
						link.sdin <= tx[`SEW_TX_W-1];
						tx        <= {tx[`SEW_TX_W-2:0], 1'b0};
					end
					if (ph == HALF)
					begin
						link.sclk <= 1'b1;
						nleft     <= nleft - 5'h01;
						if (nleft == 5'h01)
						begin
							st <= rd ? sew_pkg::SEW_M_READ :
								sew_pkg::SEW_M_DROP;
							if (rd)
								nleft <= x16 ? `SEW_X16_DBITS :
									`SEW_X8_DBITS;
						end
					end
				end
				sew_pkg::SEW_M_READ:
				begin
					// the first sample is the dummy zero
					if (ph == HALF - 8'h01)
						rsh <= {rsh[14:0], do2};
					if (ph == HALF)
					begin
						if (nleft == 5'h00)
							st <= sew_pkg::SEW_M_DROP;
						else
						begin
							link.sclk <= 1'b1;
							nleft     <= nleft - 5'h01;
						end
					end
				end
				sew_pkg::SEW_M_DROP:
				begin
					if (ph == LAST)
					begin
						link.sel  <= 1'b0;
						link.sdin <= 1'b0;
						rsp_valid <= !prog;
						rsp_data  <= !rd ? 16'h0000 :
							(x16 ? rsh : {8'h00, rsh[7:0]});
						st <= prog ? sew_pkg::SEW_M_GAP :
							sew_pkg::SEW_M_IDLE;
					end
				end
				sew_pkg::SEW_M_GAP:
				begin
					if (gap_ok && (ph == LAST))
					begin
						link.sel <= 1'b1;
						st       <= sew_pkg::SEW_M_POLL;
					end
				end
				sew_pkg::SEW_M_POLL:
				begin
					if (do2 && (ph == LAST))
						st <= sew_pkg::SEW_M_CLEAR;
				end
				sew_pkg::SEW_M_CLEAR:
				begin
					if (ph == 8'h00)
						link.sdin <= 1'b1;
					if (ph == HALF)
					begin
						link.sclk <= 1'b1;
						prog      <= 1'b0;
						rd        <= 1'b0;
						st        <= sew_pkg::SEW_M_DROP;
					end
				end
				default:
					st <= sew_pkg::SEW_M_IDLE;
			endcase
		end
	end

endmodule : sew_mst

`default_nettype wire

// >>> dv/sew_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sew_cfg.svh"

module sew_link_chk #(
	parameter int unsigned PROG_CYCLES = 200
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// link
	input  wire logic sel,
	input  wire logic sclk,
	input  wire logic sdin,
	input  wire logic sdout,
	input  wire logic sdout_oe_n,
	// device status
	input  wire logic busy
);
	localparam int TCSL_CYC = `SEW_TCSL_NS / `SEW_CLK_NS;

	logic [7:0]  low_cnt;
	logic [15:0] busy_cnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	// saturates so a long idle stretch never wraps below the gap figure
	always_ff @(posedge clk)
	begin
		if (!rst_n || sel)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || !busy)
			busy_cnt <= 16'h0000;
		else
			busy_cnt <= busy_cnt + 16'h0001;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_status_up;
		##[3:4] (!sdout_oe_n && !sdout);
	endsequence

	sequence s_ready_up;
		##[1:5] (!sdout_oe_n && sdout);
	endsequence

	chk_oe_standby: assert property (
		(!sel)[*5] |-> sdout_oe_n)
		else $error("data output driven while deselected");
	chk_sel_gap: assert property (
		$rose(sel) |-> low_cnt >= 8'(TCSL_CYC))
		else $error("select low time too short");
	chk_sclk_quiet: assert property (
		(!sel)[*2] |-> !sclk)
		else $error("link clock toggles while deselected");
	chk_din_stable: assert property (
		$rose(sclk) && sel |-> $stable(sdin) ##1 $stable(sdin))
		else $error("serial input moves at sampling edge");
	// status flips with busy, so changes near its fall are left out
	chk_rd_shift: assert property (
		$changed(sdout) && !sdout_oe_n && !$past(sdout_oe_n) &&
		!$past(busy, 6) |-> $past(sclk, 3) && !$past(sclk, 5))
		else $error("read bit changed without a clock rise");
	chk_prog_start: assert property (
		$rose(busy) |-> !sel && !sclk)
		else $error("programming started while clocked");
	chk_busy_len: assert property (
		$fell(busy) |-> busy_cnt == 16'(PROG_CYCLES))
		else $error("programming time wrong");
	chk_status_on: assert property (
		$rose(sel) && busy |-> s_status_up)
		else $error("busy status not shown");
	chk_ready_shown: assert property (
		$fell(busy) && sel |-> s_ready_up)
		else $error("ready status not shown");
endmodule : sew_link_chk

`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sew_cfg.svh"

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
	error_cnt++; $display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end end

module tb_top;
	localparam int PROG  = 200;
	localparam int LIMIT = 40000;

	logic        clk;
	logic        rst_n;
	logic        width_strap;
	logic        busy;
	logic        req_valid;
	logic        req_ready;
	logic [1:0]  req_op;
	logic [7:0]  req_addr;
	logic [15:0] req_data;
	logic        req_x16;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic [15:0] q;
	int          error_cnt;
	int          n_compared;
	int          cyc;

	sew_link_if link_if ();

	sew_mst sew_mst_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (1'b1),
		.req_valid (req_valid),
		.req_ready (req_ready),
		.req_op    (req_op),
		.req_addr  (req_addr),
		.req_data  (req_data),
		.req_x16   (req_x16),
		.rsp_valid (rsp_valid),
		.rsp_data  (rsp_data),
		.link      (link_if)
	);

	sew_dev #(
		.VARIANT     (sew_pkg::SEW_VAR_STRAP),
		.PROG_CYCLES (PROG)
	) sew_dev_inst (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (1'b1),
		.width_strap (width_strap),
		.busy        (busy),
		.link        (link_if)
	);

	sew_link_chk #(.PROG_CYCLES(PROG)) chk_inst (
		.clk        (clk),
		.rst_n      (rst_n),
		.sel        (link_if.sel),
		.sclk       (link_if.sclk),
		.sdin       (link_if.sdin),
		.sdout      (link_if.sdout),
		.sdout_oe_n (link_if.sdout_oe_n),
		.busy       (busy)
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			end_sim();
		end
	end

	// waits out the previous frame, then hands one request over
	task automatic xfer(input logic [1:0] op, input logic [7:0] a,
		input logic [15:0] d, input logic x16);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 2000);
		`CHK("req_ready", 1'b1, req_ready)
		@(posedge clk);
		req_op <= op;
		req_addr <= a;
		req_data <= d;
		req_x16 <= x16;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		if (op == `SEW_OP_READ || op == 2'h0)
		begin
			do
			begin
				@(negedge clk);
				n++;
			end
			while (rsp_valid !== 1'b1 && n < 2000);
			`CHK("rsp_valid", 1'b1, rsp_valid)
			q = rsp_data;
		end
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic x16,
		input logic [15:0] ex);
		xfer(`SEW_OP_READ, a, 16'h0000, x16);
		`CHK("read_data", ex, q)
	endtask : rd

	// the strap is resampled only on link clock rises, so a spare
	// no-op frame carries a new level in before the next command
	task automatic set_strap(input logic v);
		@(posedge clk);
		width_strap <= v;
		xfer(2'h0, 8'h00, 16'h0000, v);
		`CHK("strap_noop", 16'h0000, q)
	endtask : set_strap

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_noop();
		xfer(2'h0, 8'h00, 16'h0000, 1'b0);
		`CHK("noop_data", 16'h0000, q)
		`CHK("noop_busy", 1'b0, busy)
	endtask : t_noop

	task automatic t_rw_x8();
		set_strap(1'b0);
		xfer(`SEW_OP_WRITE, 8'h00, 16'h00a5, 1'b0);
		xfer(`SEW_OP_WRITE, 8'hff, 16'h003c, 1'b0);
		rd(8'h00, 1'b0, 16'h00a5);
		rd(8'hff, 1'b0, 16'h003c);
	endtask : t_rw_x8

	task automatic t_erase();
		int n;
		xfer(`SEW_OP_ERASE, 8'h00, 16'h0000, 1'b0);
		n = 0;
		while (busy !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		`CHK("busy_on", 1'b1, busy)
		`CHK("ready_busy", 1'b0, req_ready)
		rd(8'h00, 1'b0, 16'h00ff);
	endtask : t_erase

	// a word sits on bytes 2a and 2a+1, high byte in the odd place
	task automatic t_rw_x16();
		set_strap(1'b1);
		xfer(`SEW_OP_WRITE, 8'h7f, 16'h1234, 1'b1);
		rd(8'h7f, 1'b1, 16'h1234);
		xfer(`SEW_OP_ERASE, 8'h00, 16'h0000, 1'b1);
		rd(8'h00, 1'b1, 16'hffff);
		set_strap(1'b0);
		rd(8'hff, 1'b0, 16'h0012);
		rd(8'hfe, 1'b0, 16'h0034);
	endtask : t_rw_x16

	task automatic t_standby();
		repeat (8) @(negedge clk);
		`CHK("sel_idle", 1'b0, link_if.sel)
		`CHK("oe_standby", 1'b1, link_if.sdout_oe_n)
	endtask : t_standby

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		width_strap = 1'b0;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_addr = 8'h00;
		req_data = 16'h0000;
		req_x16 = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_noop();
		t_rw_x8();
		t_erase();
		t_rw_x16();
		t_standby();
		end_sim();
	end
endmodule : tb_top

`default_nettype wire
